// ===== dv/dagm_properties.sv
// Concurrent checks on the address generator request and response ports
`timescale 1ns/100ps
module dagm_properties
    import dagm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests
    input wire logic g1_req,
    input wire logic [1:0] g1_op,
    input wire logic [2:0] g1_index,
    input wire logic g1_load,
    input wire logic g1_dest_data,
    input wire logic g2_req,
    input wire logic [1:0] g2_op,
    input wire logic [2:0] g2_index,
    input wire logic g2_load,
    input wire logic g2_dest_data,
    // Outputs
    input wire logic dm_addr_valid,
    input wire logic pm_addr_valid,
    input wire logic dm_load_primary,
    input wire logic dm_load_secondary,
    input wire logic pm_load_primary,
    input wire logic pm_load_secondary
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Memory accesses
    sequence s_g1_mem;
        g1_req && g1_op != DAGM_OP_MODIFY;
    endsequence
    sequence s_g2_mem;
        g2_req && g2_op != DAGM_OP_MODIFY;
    endsequence
    AST_DM_VALID: assert property (s_g1_mem |=> dm_addr_valid)
        else $error("dm address valid missing");
    AST_DM_QUIET: assert property (!g1_req || g1_op == DAGM_OP_MODIFY |=> !dm_addr_valid)
        else $error("dm address valid without access");
    AST_PM_VALID: assert property (s_g2_mem |=> pm_addr_valid)
        else $error("pm address valid missing");
    AST_PM_QUIET: assert property (!g2_req || g2_op == DAGM_OP_MODIFY |=> !pm_addr_valid)
        else $error("pm address valid without access");
    AST_DM_LOAD: assert property (s_g1_mem ##0 g1_load |=> dm_load_primary)
        else $error("dm load missing");
    AST_DM_BCAST: assert property (
        g1_req && !(g1_load && g1_dest_data && g1_index == 3'h1) |=> !dm_load_secondary)
        else $error("dm broadcast without cause");
    AST_PM_BCAST: assert property (
        g2_req && !(g2_load && g2_dest_data && g2_index == 3'h1) |=> !pm_load_secondary)
        else $error("pm broadcast without cause");
    AST_PM_STORE: assert property (
        s_g2_mem ##0 !g2_load |=> !pm_load_primary && !pm_load_secondary)
        else $error("pm load on store");
    AST_BCAST_PAIR: assert property (dm_load_secondary |-> dm_load_primary)
        else $error("dm broadcast without named load");
endmodule // dagm_properties

// ===== dv/dagm_seq_model.sv
// Instruction sequencer model that issues generator requests
`timescale 1ns/100ps
module dagm_seq_model
    import dagm_pkg::*;
(
    // Clock
    input wire logic aclk,
    // First generator request
    output logic g1_req,
    output logic [1:0] g1_op,
    output logic [2:0] g1_index,
    output logic [2:0] g1_modsel,
    output logic g1_use_imm,
    output logic [31:0] g1_imm,
    output logic g1_load,
    output logic g1_dest_data,
    // Second generator request
    output logic g2_req,
    output logic [1:0] g2_op,
    output logic [2:0] g2_index,
    output logic [2:0] g2_modsel,
    output logic g2_use_imm,
    output logic [31:0] g2_imm,
    output logic g2_load,
    output logic g2_dest_data
);
    int st [2][8];
    initial begin
        {g1_req, g1_op, g1_index, g1_modsel, g1_use_imm, g1_imm, g1_load, g1_dest_data} = '0;
        {g2_req, g2_op, g2_index, g2_modsel, g2_use_imm, g2_imm, g2_load, g2_dest_data} = '0;
    end
    task automatic set(input int g, o, i, m, u, v, l, d);
        st[g] = '{o, i, m, u, v, l, d, 0};
    endtask
    // Generators selected by r1 and r2 issue in one cycle, then fields go stale
    task automatic fire(input logic r1, input logic r2);
        @(posedge aclk);
        g1_req <= r1;
        {g1_op, g1_index, g1_modsel} <= {st[0][0][1:0], st[0][1][2:0], st[0][2][2:0]};
        {g1_use_imm, g1_imm, g1_load, g1_dest_data} <= {st[0][3][0], st[0][4], st[0][5][0], st[0][6][0]};
        g2_req <= r2;
        {g2_op, g2_index, g2_modsel} <= {st[1][0][1:0], st[1][1][2:0], st[1][2][2:0]};
        {g2_use_imm, g2_imm, g2_load, g2_dest_data} <= {st[1][3][0], st[1][4], st[1][5][0], st[1][6][0]};
        @(posedge aclk);
        g1_req <= 1'b0;
        g2_req <= 1'b0;
        g1_imm <= ~g1_imm;
        g2_imm <= ~g2_imm;
        #1;
    endtask
    // Callers let a bus cycle pass after a bank switch before use
endmodule // dagm_seq_model

// ===== dv/tb_data_address_generator_modes.sv
// Self-checking bench for the address generator pair
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_data_address_generator_modes;
    import dagm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, dm_addr, pm_addr, g1_imm, g2_imm;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, g1_op, g2_op;
    logic [2:0] g1_index, g1_modsel, g2_index, g2_modsel;
    logic g1_req, g1_use_imm, g1_load, g1_dest_data;
    logic g2_req, g2_use_imm, g2_load, g2_dest_data;
    logic dm_addr_valid, pm_addr_valid, dm_load_primary, dm_load_secondary;
    logic pm_load_primary, pm_load_secondary, secondary_element_enable;
    logic [3:0] loads;
    assign loads = {dm_load_primary, dm_load_secondary, pm_load_primary, pm_load_secondary};
    int err_total = 0;
    int num_checks = 0;
    always #2 aclk = ~aclk;
    dagm_top i_dut (.*);
    dagm_seq_model i_seq (.*);
    // ==========================================
    // Helpers
    function automatic logic [11:0] rga(input logic [1:0] t, input logic [3:0] n);
        return REG_BASE_ADDR | {4'h0, t, n, 2'h0};
    endfunction
    function automatic logic [31:0] brev(input logic [31:0] x);
        for (int i = 0; i < 32; i++) brev[31 - i] = x[i];
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        `CHK("bresp", RESP_OKAY, r)
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, r)
        if (er == RESP_OKAY) `CHK("rdata", e, d)
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd(MODE_ADDR, 32'h0, RESP_OKAY);
        rd(12'h00C, 32'h0, RESP_SLVERR);
        wr(MODE_ADDR, 32'hFFFF_FFFF);
        rd(MODE_ADDR, MODE_MASK, RESP_OKAY);
        wr(MODE_ADDR, 32'h0);
    endtask
    task automatic t_modify();
        wr(rga(2'h3, 4'h0), 32'h1000);
        rd(rga(2'h0, 4'h0), 32'h1000, RESP_OKAY);
        wr(rga(2'h1, 4'h1), 32'h4);
        i_seq.set(0, 0, 0, 1, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", 32'h1000, dm_addr)
        rd(rga(2'h0, 4'h0), 32'h1004, RESP_OKAY);
        i_seq.set(0, 1, 0, 1, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", 32'h1008, dm_addr)
        rd(rga(2'h0, 4'h0), 32'h1004, RESP_OKAY);
        i_seq.set(0, 2, 0, 1, 0, 0, 0, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr_valid", 1'b0, dm_addr_valid)
        rd(rga(2'h0, 4'h0), 32'h1008, RESP_OKAY);
        wr(rga(2'h3, 4'h8), 32'h2000);
        wr(rga(2'h1, 4'h8), 32'h10);
        i_seq.set(1, 0, 0, 0, 0, 0, 1, 0);
        i_seq.fire(1'b0, 1'b1);
        `CHK("pm_addr", 32'h2000, pm_addr)
        rd(rga(2'h0, 4'h8), 32'h2010, RESP_OKAY);
        rd(rga(2'h0, 4'h0), 32'h1008, RESP_OKAY);
    endtask
    task automatic t_brev();
        wr(MODE_ADDR, 32'h3);
        i_seq.set(0, 0, 0, 1, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", brev(32'h1008), dm_addr)
        rd(rga(2'h0, 4'h0), 32'h100C, RESP_OKAY);
        i_seq.set(0, 1, 0, 1, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", brev(32'h1010), dm_addr)
        i_seq.set(1, 1, 0, 0, 0, 0, 1, 0);
        i_seq.fire(1'b0, 1'b1);
        `CHK("pm_addr", brev(32'h2020), pm_addr)
        wr(MODE_ADDR, 32'h0);
        i_seq.fire(1'b1, 1'b1);
        `CHK("dm_addr", 32'h1010, dm_addr)
        `CHK("pm_addr", 32'h2020, pm_addr)
    endtask
    task automatic t_circ();
        wr(MODE_ADDR, 32'h0100_0000);
        wr(rga(2'h3, 4'h7), 32'h300);
        wr(rga(2'h2, 4'h7), 32'h2);
        i_seq.set(0, 0, 7, 0, 1, 1, 0, 0);
        for (int k = 0; k < 3; k++) begin
            i_seq.fire(1'b1, 1'b0);
            `CHK("dm_addr", 32'h300 + 32'(k % 2), dm_addr)
        end
        rd(STICKY_ADDR, 32'h1, RESP_OKAY);
        wr(STICKY_ADDR, 32'h1);
        rd(STICKY_ADDR, 32'h0, RESP_OKAY);
        wr(MODE_ADDR, 32'h0);
        i_seq.fire(1'b1, 1'b0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", 32'h302, dm_addr)
    endtask
    task automatic t_bcast();
        logic [31:0] md [5] = '{32'h00C0_0000, 32'h00E0_0000, 32'h0080_0000,
            32'h0040_0000, 32'h0};
        logic [3:0] ex [5] = '{4'hF, 4'hF, 4'hE, 4'hB, 4'hA};
        for (int k = 0; k < 5; k++) begin
            wr(MODE_ADDR, md[k]);
            `CHK("secondary_element_enable", md[k][21], secondary_element_enable)
            i_seq.set(0, 0, 1, 0, 0, 0, 1, 1);
            i_seq.set(1, 0, 1, 0, 0, 0, 1, 1);
            i_seq.fire(1'b1, 1'b1);
            `CHK("loads", ex[k], loads)
        end
        wr(MODE_ADDR, 32'h00C0_0000);
        i_seq.set(0, 0, 1, 0, 0, 0, 0, 1);
        i_seq.set(1, 0, 1, 0, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b1);
        `CHK("loads", 4'h2, loads)
        i_seq.set(0, 0, 2, 0, 0, 0, 1, 1);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_load_secondary", 1'b0, dm_load_secondary)
        wr(MODE_ADDR, 32'h0);
    endtask
    task automatic t_bank();
        wr(rga(2'h0, 4'h0), 32'h55);
        wr(MODE_ADDR, 32'h10);
        rd(ACTIVE_BANK_ADDR, 32'h10, RESP_OKAY);
        rd(rga(2'h0, 4'h0), 32'h0, RESP_OKAY);
        wr(rga(2'h0, 4'h0), 32'hAA);
        i_seq.set(0, 0, 0, 1, 0, 0, 1, 0);
        i_seq.fire(1'b1, 1'b0);
        `CHK("dm_addr", 32'hAA, dm_addr)
        wr(MODE_ADDR, 32'h0);
        rd(rga(2'h0, 4'h0), 32'h55, RESP_OKAY);
        wr(MODE_ADDR, 32'h10);
        rd(rga(2'h0, 4'h0), 32'hAA, RESP_OKAY);
        wr(MODE_ADDR, 32'h0);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modify();
        t_brev();
        t_circ();
        t_bcast();
        t_bank();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        report_and_stop();
    end
endmodule // tb_data_address_generator_modes
bind dagm_top dagm_properties i_props (.*);

// ===== hw/dagm_top.sv
// Data address generator pair with register bank switching and AXI4-Lite access
`timescale 1ns/100ps
module dagm_top
    import dagm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // First generator request
    input wire logic g1_req,
    input wire logic [1:0] g1_op,
    input wire logic [2:0] g1_index,
    input wire logic [2:0] g1_modsel,
    input wire logic g1_use_imm,
    input wire logic [31:0] g1_imm,
    input wire logic g1_load,
    input wire logic g1_dest_data,
    // Second generator request
    input wire logic g2_req,
    input wire logic [1:0] g2_op,
    input wire logic [2:0] g2_index,
    input wire logic [2:0] g2_modsel,
    input wire logic g2_use_imm,
    input wire logic [31:0] g2_imm,
    input wire logic g2_load,
    input wire logic g2_dest_data,
    // Memory address outputs
    output logic [31:0] dm_addr,
    output logic dm_addr_valid,
    output logic [31:0] pm_addr,
    output logic pm_addr_valid,
    // Processing element load steering
    output logic dm_load_primary,
    output logic dm_load_secondary,
    output logic pm_load_primary,
    output logic pm_load_secondary,
    // Mode outputs
    output logic secondary_element_enable
);

    // ==========================================
    // Helper functions
    function automatic logic [31:0] bit_reverse(input logic [31:0] a);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[31 - i] = a[i];
        end
        return r;
    endfunction

    // Bank select bit for a register number
    function automatic logic bank_of(input logic [3:0] n, input logic [31:0] sel);
        logic b;
        b = 1'b0;
        unique case (n[3:2])
            2'h0: b = sel[ALT_G1L_BIT];
            2'h1: b = sel[ALT_G1H_BIT];
            2'h2: b = sel[ALT_G2L_BIT];
            2'h3: b = sel[ALT_G2H_BIT];
        endcase
        return b;
    endfunction

    // ==========================================
    // Register storage: [bank][number]
    logic [31:0] index_reg [2][NUM_REGS];
    logic [31:0] modify_reg [2][NUM_REGS];
    logic [31:0] length_reg [2][NUM_REGS];
    logic [31:0] base_reg [2][NUM_REGS];
    logic [31:0] address_generator_mode;
    logic [31:0] bank_sel;
    logic [1:0] sticky_status;

    // ==========================================
    // AXI write channel
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_reg_hit, wr_ok;
    logic [1:0] wr_type;
    logic [3:0] wr_num;
    logic [31:0] wr_merge_mode;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_reg_hit = (aw_addr[11:8] == REG_BASE_ADDR[11:8]);
    assign wr_type = aw_addr[REG_TYPE_LSB +: 2];
    assign wr_num = aw_addr[REG_SEL_LSB +: 4];
    // Sticky register takes write-one-to-clear; the bank copy is read only
    assign wr_ok = (aw_addr == MODE_ADDR)
        || (aw_addr == STICKY_ADDR)
        || wr_reg_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte-lane merge for the mode register
    always_comb begin
        wr_merge_mode = address_generator_mode;
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                wr_merge_mode[b*8 +: 8] = w_data[b*8 +: 8];
            end
        end
        wr_merge_mode = wr_merge_mode & MODE_MASK;
    end

    // ==========================================
    // Mode register and delayed bank select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            address_generator_mode <= MODE_RESET;
        end else if (wr_fire && aw_addr == MODE_ADDR) begin
            address_generator_mode <= wr_merge_mode;
        end
    end

    // Banks follow the mode one cycle late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_sel <= MODE_RESET;
        end else begin
            bank_sel <= address_generator_mode;
        end
    end

    assign secondary_element_enable = address_generator_mode[SEC_EN_BIT];

    // ==========================================
    // Address generation, one generator per instance of the loop
    logic [31:0] gen_addr [2];
    logic gen_addr_valid [2];
    logic gen_wr [2];
    logic [3:0] gen_num [2];
    logic gen_bank [2];
    logic [31:0] gen_next [2];
    logic gen_ovf [2];
    logic gen_bcast [2];

    for (genvar g = 0; g < 2; g++) begin : g_gen
        logic req, use_imm, load, dest_data;
        logic [1:0] op;
        logic [3:0] num, mnum;
        logic [31:0] imm, idx, mdf, len, bas, sum, wrapped, out;
        logic brev_en, bcast_en, circ;
        assign req = (g == 0) ? g1_req : g2_req;
        assign op = (g == 0) ? g1_op : g2_op;
        // Generator number supplies the top bit of the register number
        assign num = {1'(g), ((g == 0) ? g1_index : g2_index)};
        assign mnum = {1'(g), ((g == 0) ? g1_modsel : g2_modsel)};
        assign use_imm = (g == 0) ? g1_use_imm : g2_use_imm;
        assign imm = (g == 0) ? g1_imm : g2_imm;
        assign load = (g == 0) ? g1_load : g2_load;
        assign dest_data = (g == 0) ? g1_dest_data : g2_dest_data;
        // Operands come from whichever bank is active this cycle
        assign idx = index_reg[bank_of(num, bank_sel)][num];
        assign mdf = use_imm ? imm : modify_reg[bank_of(mnum, bank_sel)][mnum];
        assign len = length_reg[bank_of(num, bank_sel)][num];
        assign bas = base_reg[bank_of(num, bank_sel)][num];
        assign sum = idx + mdf;
        assign circ = address_generator_mode[CIRC_BIT] && (len != '0);
        assign brev_en = (g == 0)
            ? (address_generator_mode[BREV1_BIT] && num == IDX_BREV1)
            : (address_generator_mode[BREV2_BIT] && num == IDX_BREV2);
        assign bcast_en = (g == 0)
            ? (address_generator_mode[BCAST1_BIT] && num == IDX_BCAST1)
            : (address_generator_mode[BCAST9_BIT] && num == IDX_BCAST2);

        // Wrap back into [base, base+length)
        always_comb begin
            wrapped = sum;
            if (circ && sum >= bas + len) begin
                wrapped = sum - len;
            end else if (circ && sum < bas) begin
                wrapped = sum + len;
            end
        end

        // Pre-modify outputs the sum, post-modify the stored index
        assign out = (op == DAGM_OP_PRE) ? sum : idx;
        assign gen_addr[g] = brev_en ? bit_reverse(out) : out;
        assign gen_addr_valid[g] = req && (op != DAGM_OP_MODIFY);
        assign gen_wr[g] = req && (op != DAGM_OP_PRE);
        assign gen_num[g] = num;
        assign gen_bank[g] = bank_of(num, bank_sel);
        assign gen_next[g] = wrapped;
        // Only the last index of each generator reports a wrap
        assign gen_ovf[g] = gen_wr[g] && circ && (wrapped != sum)
            && (num == ((g == 0) ? IDX_OVF1 : IDX_OVF2));
        // Broadcast needs a load into a data register, mode bit 21 not involved
        assign gen_bcast[g] = req && load && dest_data && bcast_en;
    end

    // ==========================================
    // Register writes: software and generator updates
    logic sw_reg_wr;
    logic sw_bank;
    assign sw_reg_wr = wr_fire && wr_reg_hit;
    assign sw_bank = bank_of(wr_num, bank_sel);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int b = 0; b < 2; b++) begin
                for (int n = 0; n < NUM_REGS; n++) begin
                    index_reg[b][n] <= '0;
                    modify_reg[b][n] <= '0;
                    length_reg[b][n] <= '0;
                    base_reg[b][n] <= '0;
                end
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (gen_wr[g]) begin
                    index_reg[gen_bank[g]][gen_num[g]] <= gen_next[g];
                end
            end
            if (sw_reg_wr) begin
                unique case (wr_type)
                    TYPE_INDEX: index_reg[sw_bank][wr_num] <= w_data;
                    TYPE_MODIFY: modify_reg[sw_bank][wr_num] <= w_data;
                    TYPE_LENGTH: length_reg[sw_bank][wr_num] <= w_data;
                    TYPE_BASE: begin
                        base_reg[sw_bank][wr_num] <= w_data;
                        index_reg[sw_bank][wr_num] <= w_data;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Sticky overflow flags, write one to clear, set wins
    logic [1:0] sticky_clr;
    assign sticky_clr = (wr_fire && aw_addr == STICKY_ADDR && w_strb[0])
        ? w_data[OVF2_BIT:OVF1_BIT] : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_status <= '0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (gen_ovf[g]) begin
                    sticky_status[g] <= 1'b1;
                end else if (sticky_clr[g]) begin
                    sticky_status[g] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // Memory address and load steering outputs
    // Registered so the memory side sees each address one cycle after its request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dm_addr <= '0;
            pm_addr <= '0;
            dm_addr_valid <= 1'b0;
            pm_addr_valid <= 1'b0;
            dm_load_primary <= 1'b0;
            dm_load_secondary <= 1'b0;
            pm_load_primary <= 1'b0;
            pm_load_secondary <= 1'b0;
        end else begin
            dm_addr <= gen_addr[0];
            pm_addr <= gen_addr[1];
            dm_addr_valid <= gen_addr_valid[0];
            pm_addr_valid <= gen_addr_valid[1];
            dm_load_primary <= gen_addr_valid[0] && g1_load;
            pm_load_primary <= gen_addr_valid[1] && g2_load;
            dm_load_secondary <= gen_addr_valid[0] && gen_bcast[0];
            pm_load_secondary <= gen_addr_valid[1] && gen_bcast[1];
        end
    end

    // ==========================================
    // AXI read channel
    logic [31:0] rd_value;
    logic rd_ok;
    logic rd_bank;
    logic [3:0] rd_num;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_num = s_axi_araddr[REG_SEL_LSB +: 4];
    assign rd_bank = bank_of(rd_num, bank_sel);

    // Unmapped addresses read as zero and answer with an error

    always_comb begin
        rd_value = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr == MODE_ADDR) begin
            rd_value = address_generator_mode;
        end else if (s_axi_araddr == STICKY_ADDR) begin
            rd_value = {30'h0000_0000, sticky_status};
        end else if (s_axi_araddr == ACTIVE_BANK_ADDR) begin
            rd_value = bank_sel & MODE_MASK;
        end else if (s_axi_araddr[11:8] == REG_BASE_ADDR[11:8]) begin
            unique case (s_axi_araddr[REG_TYPE_LSB +: 2])
                TYPE_INDEX: rd_value = index_reg[rd_bank][rd_num];
                TYPE_MODIFY: rd_value = modify_reg[rd_bank][rd_num];
                TYPE_LENGTH: rd_value = length_reg[rd_bank][rd_num];
                TYPE_BASE: rd_value = base_reg[rd_bank][rd_num];
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // dagm_top

// ===== shared/dagm_pkg.sv
// Package for the data address generator block: register map, mode bits, op codes
package dagm_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [11:0] MODE_ADDR = 12'h000;
    localparam logic [11:0] STICKY_ADDR = 12'h004;
    localparam logic [11:0] ACTIVE_BANK_ADDR = 12'h008;
    localparam logic [11:0] REG_BASE_ADDR = 12'h100;
    localparam int REG_TYPE_LSB = 6;
    localparam int REG_SEL_LSB = 2;
    // ==========================================
    // Mode register bits
    localparam int CIRC_BIT = 24;
    localparam int BCAST1_BIT = 23;
    localparam int BCAST9_BIT = 22;
    localparam int SEC_EN_BIT = 21;
    localparam int ALT_G2L_BIT = 6;
    localparam int ALT_G2H_BIT = 5;
    localparam int ALT_G1L_BIT = 4;
    localparam int ALT_G1H_BIT = 3;
    localparam int BREV1_BIT = 1;
    localparam int BREV2_BIT = 0;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_MASK = 32'h01E0_007B;
    // ==========================================
    // Register types and fixed indexes
    localparam logic [1:0] TYPE_INDEX = 2'h0;
    localparam logic [1:0] TYPE_MODIFY = 2'h1;
    localparam logic [1:0] TYPE_LENGTH = 2'h2;
    localparam logic [1:0] TYPE_BASE = 2'h3;
    localparam logic [3:0] IDX_BREV1 = 4'h0;
    localparam logic [3:0] IDX_BCAST1 = 4'h1;
    localparam logic [3:0] IDX_OVF1 = 4'h7;
    localparam logic [3:0] IDX_BREV2 = 4'h8;
    localparam logic [3:0] IDX_BCAST2 = 4'h9;
    localparam logic [3:0] IDX_OVF2 = 4'hF;
    localparam int NUM_REGS = 16;
    // Sticky flag positions
    localparam int OVF1_BIT = 0;
    localparam int OVF2_BIT = 1;
    // ==========================================
    // Instruction operation codes
    typedef enum logic [1:0] {
        DAGM_OP_POST = 2'h0,
        DAGM_OP_PRE = 2'h1,
        DAGM_OP_MODIFY = 2'h2
    } dagm_op_t;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
